// ### sfrpe_core.sv
`timescale 1ns/1ps
`include "sfrpe_defs.svh"
module sfrpe_core #(
  parameter int DEPTH = 2,
  parameter int TPP_CYC = (`SFRPE_TPP_US * 1000) / `SFRPE_CLK_NS,
  parameter int TSE_CYC = (`SFRPE_TSE_US * 1000) / `SFRPE_CLK_NS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  input wire logic i_quad_io_enable_bit,
  input wire logic i_wel_set,
  input wire logic i_soft_reset,
  input wire sfrpe_pkg::sfrpe_prot_t i_prot,
  input wire logic i_lock_hit,
  output logic [23:0] o_addr,
  input wire logic [7:0] i_rd_data,
  output sfrpe_pkg::sfrpe_pgm_t o_pgm,
  output logic o_pgm_valid,
  input wire logic i_pgm_ready,
  output sfrpe_pkg::sfrpe_op_t o_op,
  output logic o_op_valid,
  output logic o_op_abort,
  output logic o_busy,
  output logic o_write_enable_latch,
  output logic [2:0] o_wrap_setting_bits,
  output logic o_cont_mode
);
  import sfrpe_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // sector, block or whole-array protection from the protect bits
  function automatic logic prot_hit(input logic [23:0] a,
                                    input sfrpe_prot_t p);
    logic [23:0] size;
    logic [23:0] off;
    logic [2:0] sh;
    sh = p.protect_range_bits - 3'h1;
    if (p.protect_range_bits == 3'h0) begin
      size = 24'h0;
    end else if (p.protect_granularity_bit) begin
      if (sh > `SFRPE_SEC_SHIFT_MAX) begin
        sh = `SFRPE_SEC_SHIFT_MAX;
      end
      size = `SFRPE_SEC_UNIT << sh;
    end else if (p.protect_range_bits == `SFRPE_BP_ALL) begin
      size = `SFRPE_ARRAY_ALL;
    end else begin
      size = `SFRPE_BLK_UNIT << sh;
    end
    off = p.protect_top_bottom_bit ? {1'b0, a[22:0]} : {1'b0, ~a[22:0]};
    return (off < size) ^ p.protect_complement_bit;
  endfunction : prot_hit

  // next read address, cycling inside an aligned wrap section unless wrap bit 0 is set
  function automatic logic [23:0] next_addr(input logic [23:0] a,
                                            input logic [2:0] w);
    logic [23:0] mask;
    mask = (`SFRPE_WRAP_MIN << w[2:1]) - 24'h1;
    if (w[0]) begin
      return a + 24'h1;
    end
    return (a & ~mask) | ((a + 24'h1) & mask);
  endfunction : next_addr

  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic sck_s3_q;
  logic cs_s3_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_n;
  logic cs_rise;
  logic cs_fall;
  logic [3:0] io;
  sfrpe_state_t state_q;
  sfrpe_state_t dec_state;
  logic [5:0] cnt_q;
  logic [31:0] sh_q;
  logic [23:0] addr_q;
  logic [7:0] cmd;
  logic [7:0] mode;
  logic [7:0] pbyte;
  logic quad_q;
  logic got_q;
  logic ovf_q;
  logic nib_hi_q;
  logic cont_q;
  logic [2:0] wrap_q;
  logic pend_q;
  logic abort_q;
  sfrpe_op_t op_q;
  logic wel_q;
  logic [31:0] tmr_q;
  logic launch;
  logic done;
  logic busy;
  logic push;
  logic commit;
  logic in_ready;
  sfrpe_pgm_t mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] fcnt_q;

  // pin synchronisers, sck and select edges
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_q <= `SFRPE_PIN_IDLE;
      pin_s2_q <= `SFRPE_PIN_IDLE;
      sck_s3_q <= 1'b0;
      cs_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= {i_sck, i_cs_n, i_io};
      pin_s2_q <= pin_s1_q;
      sck_s3_q <= pin_s2_q[5];
      cs_s3_q <= pin_s2_q[4];
    end
  end

  assign sck_rise = pin_s2_q[5] & ~sck_s3_q;
  assign sck_fall = ~pin_s2_q[5] & sck_s3_q;
  assign cs_n = pin_s2_q[4];
  assign cs_rise = cs_n & ~cs_s3_q;
  assign cs_fall = ~cs_n & cs_s3_q;
  assign io = pin_s2_q[3:0];
  assign cmd = {sh_q[6:0], io[0]};
  assign mode = {sh_q[3:0], io};
  assign pbyte = quad_q ? {sh_q[3:0], io} : {sh_q[6:0], io[0]};
  assign busy = pend_q | (tmr_q != 32'h0);

  // command decode with enable checks
  always_comb begin
    case (cmd)
      `SFRPE_CMD_OWQR: dec_state = i_quad_io_enable_bit ? S_RADDR : S_SKIP;
      `SFRPE_CMD_WRAP: dec_state = S_WDUMMY;
      `SFRPE_CMD_PP: dec_state = wel_q ? S_PADDR : S_SKIP;
      `SFRPE_CMD_QPP: dec_state = (wel_q & i_quad_io_enable_bit) ?
                                  S_PADDR : S_SKIP;
      `SFRPE_CMD_SE: dec_state = wel_q ? S_EADDR : S_SKIP;
      default: dec_state = S_SKIP;
    endcase
  end

  // byte complete in program data phase
  assign push = sck_rise & ~cs_n & (state_q == S_PDATA) &
                (cnt_q == (quad_q ? `SFRPE_QBYTE_LAST : `SFRPE_CMD_LAST));
  // select rise on a whole byte with nothing lost
  assign commit = (state_q == S_PDATA) & (cnt_q == 6'h0) & got_q & ~ovf_q;

  // frame sequencer
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= S_SKIP;
      cnt_q <= 6'h0;
      sh_q <= 32'h0;
      addr_q <= 24'h0;
      quad_q <= 1'b0;
      got_q <= 1'b0;
      ovf_q <= 1'b0;
      nib_hi_q <= 1'b1;
      cont_q <= 1'b0;
      wrap_q <= `SFRPE_WRAP_RST;
      pend_q <= 1'b0;
      abort_q <= 1'b0;
      op_q <= '0;
    end else begin
      abort_q <= 1'b0;
      if (launch) begin
        pend_q <= 1'b0;
      end
      if (i_soft_reset) begin
        wrap_q <= `SFRPE_WRAP_RST;
        cont_q <= 1'b0;
      end
      if (cs_fall) begin
        // continuous mode goes straight to the address
        state_q <= busy ? S_SKIP : (cont_q ? S_RADDR : S_CMD);
        cnt_q <= 6'h0;
        got_q <= 1'b0;
        ovf_q <= 1'b0;
      end else if (cs_rise) begin
        state_q <= S_SKIP;
        if (commit || state_q == S_EDONE) begin
          if (prot_hit(addr_q, i_prot) || i_lock_hit) begin
            abort_q <= got_q;
          end else begin
            pend_q <= 1'b1;
            op_q.erase <= (state_q == S_EDONE);
            op_q.addr <= (state_q == S_EDONE) ?
                         (addr_q & `SFRPE_SECTOR_MASK) : addr_q;
          end
        end else if (state_q == S_PDATA) begin
          abort_q <= got_q;
        end
      end else if (sck_fall && !cs_n && state_q == S_RDATA) begin
        nib_hi_q <= ~nib_hi_q;
        if (!nib_hi_q) begin
          addr_q <= next_addr(addr_q, wrap_q);
        end
      end else if (sck_rise && !cs_n) begin
        cnt_q <= cnt_q + 6'h1;
        case (state_q)
          S_CMD: begin
            sh_q <= {sh_q[30:0], io[0]};
            if (cnt_q == `SFRPE_CMD_LAST) begin
              state_q <= dec_state;
              quad_q <= (cmd == `SFRPE_CMD_QPP);
              cnt_q <= 6'h0;
            end
          end
          S_RADDR: begin
            sh_q <= {sh_q[27:0], io};
            if (cnt_q == `SFRPE_QADDR_LAST) begin
              addr_q <= {sh_q[19:0], io};
              state_q <= S_MODE;
              cnt_q <= 6'h0;
            end
          end
          S_MODE: begin
            sh_q <= {sh_q[27:0], io};
            if (cnt_q == `SFRPE_QBYTE_LAST) begin
              // low nibble ignored; FFh fails the bits 5:4 check and clears the mode
              cont_q <= (mode[5:4] == `SFRPE_CONT_KEEP);
              state_q <= S_RDATA;
              nib_hi_q <= 1'b1;
              cnt_q <= 6'h0;
            end
          end
          S_WDUMMY: begin
            if (cnt_q == `SFRPE_QADDR_LAST) begin
              state_q <= S_WBITS;
              cnt_q <= 6'h0;
            end
          end
          S_WBITS: begin
            sh_q <= {sh_q[27:0], io};
            if (cnt_q == `SFRPE_QBYTE_LAST) begin
              wrap_q <= mode[6:4];
              state_q <= S_SKIP;
            end
          end
          S_PADDR, S_EADDR: begin
            sh_q <= {sh_q[30:0], io[0]};
            if (cnt_q == `SFRPE_ADDR_LAST) begin
              addr_q <= {sh_q[22:0], io[0]};
              state_q <= (state_q == S_PADDR) ? S_PDATA : S_EDONE;
              cnt_q <= 6'h0;
            end
          end
          S_PDATA: begin
            sh_q <= quad_q ? {sh_q[27:0], io} : {sh_q[30:0], io[0]};
            if (push) begin
              addr_q[7:0] <= addr_q[7:0] + 8'h1;
              got_q <= 1'b1;
              ovf_q <= ovf_q | ~in_ready;
              cnt_q <= 6'h0;
            end
          end
          S_EDONE: state_q <= S_SKIP;
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // read data drive on falling sck edges
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_io <= 4'h0;
      o_io_oe <= 4'h0;
    end else if (cs_n || state_q != S_RDATA) begin
      o_io_oe <= 4'h0;
    end else if (sck_fall) begin
      o_io_oe <= `SFRPE_OE_ALL;
      o_io <= nib_hi_q ? i_rd_data[7:4] : i_rd_data[3:0];
    end
  end

  // two-entry program byte buffer toward the array
  assign in_ready = (fcnt_q != (PW + 1)'(DEPTH));
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      fcnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      if (push && in_ready) begin
        mem_q[wp_q] <= '{addr: addr_q, data: pbyte};
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
      end
      if (o_pgm_valid && i_pgm_ready) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
      end
      fcnt_q <= fcnt_q + (PW + 1)'(push && in_ready)
                - (PW + 1)'(o_pgm_valid && i_pgm_ready);
    end
  end

  // self-timed operation, started once all bytes are drained
  assign launch = pend_q & (fcnt_q == '0);
  assign done = (tmr_q == 32'h1);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_q <= 32'h0;
    end else if (launch) begin
      tmr_q <= op_q.erase ? 32'(TSE_CYC) : 32'(TPP_CYC);
    end else if (tmr_q != 32'h0) begin
      tmr_q <= tmr_q - 32'h1;
    end
  end

  // write enable latch, set wins over completion clear
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wel_q <= 1'b0;
    end else if (i_wel_set) begin
      wel_q <= 1'b1;
    end else if (done) begin
      wel_q <= 1'b0;
    end
  end

  assign o_addr = addr_q;
  assign o_pgm = mem_q[rp_q];
  assign o_pgm_valid = (fcnt_q != '0);
  assign o_op = op_q;
  assign o_op_valid = launch;
  assign o_op_abort = abort_q;
  assign o_busy = busy;
  assign o_write_enable_latch = wel_q;
  assign o_wrap_setting_bits = wrap_q;
  assign o_cont_mode = cont_q;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_read_needs_qe: assert property (sck_rise && !cs_n && state_q == S_CMD
    && cnt_q == `SFRPE_CMD_LAST && cmd == `SFRPE_CMD_OWQR
    && !i_quad_io_enable_bit && !i_soft_reset |=> state_q == S_SKIP)
    else $error("read accepted without quad enable");
  a_cont_skips_cmd: assert property (cs_fall && cont_q && !busy
    |=> state_q == S_RADDR)
    else $error("continuous read expected address");
  a_normal_cmd: assert property (cs_fall && !cont_q && !busy
    |=> state_q == S_CMD)
    else $error("command byte expected");
  a_wrap_default: assert property (i_soft_reset && !(sck_rise && !cs_n)
    |=> wrap_q == `SFRPE_WRAP_RST)
    else $error("wrap not restored");
  a_pgm_needs_wel: assert property (sck_rise && !cs_n && state_q == S_CMD
    && cnt_q == `SFRPE_CMD_LAST && cmd == `SFRPE_CMD_PP && !wel_q
    |=> state_q == S_SKIP)
    else $error("program accepted without latch");
  a_page_wrap: assert property (push && !cs_rise
    |=> addr_q[23:8] == $past(addr_q[23:8]))
    else $error("program address left page");
  a_partial_drop: assert property (cs_rise && state_q == S_PDATA
    && cnt_q != 6'h0 && !pend_q |=> !pend_q)
    else $error("partial byte committed");
  a_busy_run: assert property (launch |=> o_busy [*3])
    else $error("busy dropped early");
  a_done_clear: assert property (done && !i_wel_set && !pend_q
    |=> !o_busy && !wel_q)
    else $error("completion left busy or latch");
  a_prot_skip: assert property (cs_rise && state_q == S_EDONE
    && (prot_hit(addr_q, i_prot) || i_lock_hit) && !pend_q
    |=> !pend_q)
    else $error("protected area erased");
  a_wrap_section: assert property (sck_fall && !cs_n
    && state_q == S_RDATA && !nib_hi_q && !wrap_q[0]
    |=> addr_q[23:6] == $past(addr_q[23:6]))
    else $error("wrap left its section");

  c_cont_read: cover property (cs_fall && cont_q && !busy);
  c_pgm_run: cover property (launch && !op_q.erase);
  c_erase_run: cover property (launch && op_q.erase);
  c_buf_full: cover property (!in_ready && !i_pgm_ready);
endmodule : sfrpe_core

// ### sfrpe_defs.svh
`ifndef SFRPE_DEFS_SVH
`define SFRPE_DEFS_SVH
// command codes
`define SFRPE_CMD_OWQR 8'hE3
`define SFRPE_CMD_WRAP 8'h77
`define SFRPE_CMD_PP 8'h02
`define SFRPE_CMD_QPP 8'h32
`define SFRPE_CMD_SE 8'h20
// continuous-read pattern in bits 5:4 that skips the command byte
`define SFRPE_CONT_KEEP 2'h2
// wrap bits 6:4 after reset: no wrapping
`define SFRPE_WRAP_RST 3'h1
`define SFRPE_WRAP_MIN 24'h000008
// last clock index of each phase
`define SFRPE_CMD_LAST 6'h07
`define SFRPE_ADDR_LAST 6'h17
`define SFRPE_QADDR_LAST 6'h05
`define SFRPE_QBYTE_LAST 6'h01
// protection geometry
`define SFRPE_SEC_UNIT 24'h001000
`define SFRPE_BLK_UNIT 24'h020000
`define SFRPE_ARRAY_ALL 24'h800000
`define SFRPE_SEC_SHIFT_MAX 3'h3
`define SFRPE_BP_ALL 3'h7
`define SFRPE_SECTOR_MASK 24'hFFF000
// pins idle: chip select high, clock low
`define SFRPE_PIN_IDLE 6'h10
`define SFRPE_OE_ALL 4'hF
// timing
`define SFRPE_CLK_NS 10
`define SFRPE_TPP_US 400
`define SFRPE_TSE_US 45000
`endif

// ### sfrpe_pkg.sv
package sfrpe_pkg;
  typedef enum logic [3:0] {
    S_CMD, S_RADDR, S_MODE, S_RDATA, S_WDUMMY, S_WBITS,
    S_PADDR, S_PDATA, S_EADDR, S_EDONE, S_SKIP
  } sfrpe_state_t;
  // protection bits from the status registers
  typedef struct packed {
    logic protect_complement_bit;
    logic protect_granularity_bit;
    logic protect_top_bottom_bit;
    logic [2:0] protect_range_bits;
  } sfrpe_prot_t;
  // one program byte toward the array page latch
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } sfrpe_pgm_t;
  // self-timed array operation
  typedef struct packed {
    logic erase;
    logic [23:0] addr;
  } sfrpe_op_t;
endpackage : sfrpe_pkg

// ### sfrpe_host.sv
`timescale 1ns/1ps
// spi mode 0 host: data set while sck low, sck idles low
module sfrpe_host (
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  input wire logic [3:0] i_io
);
  logic [3:0] q;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
    o_io_oe = 4'h0;
  end
  // one sck period, sample at the rise; r lets go before the fall
  task automatic clk(input logic [3:0] d, input logic [3:0] oe, input bit r);
    o_io = d;
    o_io_oe = oe;
    #80;
    o_sck = 1'b1;
    q = i_io;
    #40;
    if (r) o_io_oe = 4'h0;
    #40;
    o_sck = 1'b0;
  endtask : clk
  // serial byte on line zero, msb first
  task automatic sbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) clk({3'h0, b[i]}, 4'h1, 1'b0);
  endtask : sbyte
  // n quad clocks, top nibble first
  task automatic quad(input logic [31:0] v, input int n, input bit r);
    for (int i = n - 1; i >= 0; i--) clk(v[4*i +: 4], 4'hF, r && i == 0);
  endtask : quad
  // read byte, high nibble first
  task automatic rbyte(output logic [7:0] b);
    clk(4'h0, 4'h0, 1'b0);
    b[7:4] = q;
    clk(4'h0, 4'h0, 1'b0);
    b[3:0] = q;
  endtask : rbyte
  task automatic sel();
    o_cs_n = 1'b0;
    #80;
  endtask : sel
  // select high well over three system clocks between frames
  task automatic desel();
    #40;
    o_cs_n = 1'b1;
    o_io_oe = 4'h0;
    #160;
  endtask : desel
endmodule : sfrpe_host

// ### test_serial_flash_read_program_erase.sv
`timescale 1ns/1ps
`include "sfrpe_defs.svh"
module test_serial_flash_read_program_erase;
  import sfrpe_pkg::*;
  localparam int TPP = 20;
  localparam int TSE = 30;
  localparam int NW = 32'h1000000;
  logic clk_sys, rst_n, qe, write_enable_latch, srst, lock, ready;
  logic sck, cs_n, busy, latch, cont, op_valid, op_abort, pgm_valid;
  logic [3:0] h_io, h_oe, d_io, d_oe, io;
  logic [23:0] addr;
  logic [2:0] wrap;
  sfrpe_prot_t prot;
  sfrpe_pgm_t pgm;
  sfrpe_op_t op;
  sfrpe_pgm_t pq[$];
  sfrpe_op_t oq[$];
  int err_count, n_compared, n_busy, n_abort;
  // pull-ups: a line nobody drives reads high
  assign io = (d_io & d_oe) | (h_io & h_oe) | ~(d_oe | h_oe);
  sfrpe_core #(.TPP_CYC(TPP), .TSE_CYC(TSE)) dut (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_sck(sck), .i_cs_n(cs_n),
    .i_io(io), .o_io(d_io), .o_io_oe(d_oe), .i_quad_io_enable_bit(qe),
    .i_wel_set(write_enable_latch), .i_soft_reset(srst), .i_prot(prot),
    .i_lock_hit(lock), .o_addr(addr), .i_rd_data(addr[7:0] ^ 8'hA5),
    .o_pgm(pgm), .o_pgm_valid(pgm_valid), .i_pgm_ready(ready),
    .o_op(op), .o_op_valid(op_valid), .o_op_abort(op_abort),
    .o_busy(busy), .o_write_enable_latch(latch),
    .o_wrap_setting_bits(wrap), .o_cont_mode(cont)
  );
  sfrpe_host host (.o_sck(sck), .o_cs_n(cs_n), .o_io(h_io),
    .o_io_oe(h_oe), .i_io(io));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // array side: collect bytes, starts, aborts, busy time
  always @(posedge clk_sys) begin
    if (pgm_valid && ready) pq.push_back(pgm);
    if (op_valid) oq.push_back(op);
    if (op_abort) n_abort++;
    if (busy) n_busy++;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask : pulse
  // wait for the start to land, then for busy to drop
  task automatic settle();
    repeat (10) @(negedge clk_sys);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_sys);
  endtask : settle
  // quad read of n bytes; len is the wrap section, NW for none
  task automatic rd(bit cmd, logic [23:0] a, logic [7:0] m, int n, int len);
    logic [7:0] b;
    logic [7:0] e;
    logic [23:0] base;
    base = a & ~(len - 1);
    host.sel();
    if (cmd) host.sbyte(`SFRPE_CMD_OWQR);
    host.quad({8'h00, a}, 6, 1'b0);
    host.quad({24'h0, m}, 2, 1'b1);
    for (int i = 0; i < n; i++) begin
      host.rbyte(b);
      e = 8'(base + (a - base + i) % len) ^ 8'hA5;
      if (qe !== 1'b1) e = 8'hFF;
      chk("read", e, b);
    end
    host.desel();
  endtask : rd
  task automatic wrap_set(logic [7:0] w);
    host.sel();
    host.sbyte(`SFRPE_CMD_WRAP);
    host.quad(32'h0, 6, 1'b0);
    host.quad({24'h0, w}, 2, 1'b0);
    host.desel();
  endtask : wrap_set
  // code, serial address, n data bytes, x loose clocks
  task automatic wr(logic [7:0] c, logic [23:0] a, int n, int x);
    host.sel();
    host.sbyte(c);
    for (int i = 2; i >= 0; i--) host.sbyte(a[8*i +: 8]);
    for (int i = 0; i < n; i++) begin
      if (c == `SFRPE_CMD_QPP) host.quad(32'h30 + i, 2, 1'b0);
      else host.sbyte(8'h30 + 8'(i));
    end
    for (int i = 0; i < x; i++) host.clk(4'h1, 4'h1, 1'b0);
    host.desel();
    settle();
  endtask : wr
  task automatic chk_pgm(logic [23:0] a, int n);
    sfrpe_pgm_t p;
    chk("pgm count", n, pq.size());
    for (int i = 0; i < n && pq.size() > 0; i++) begin
      p = pq.pop_front();
      chk("pgm addr", {a[23:8], 8'(a[7:0] + i)}, p.addr);
      chk("pgm data", 8'h30 + 8'(i), p.data);
    end
    pq.delete();
  endtask : chk_pgm
  task automatic chk_op(bit go, logic [24:0] e);
    sfrpe_op_t o;
    chk("op count", go, oq.size());
    if (go && oq.size() > 0) begin
      o = oq.pop_front();
      chk("op", e[24:8], o[24:8]);
    end
    oq.delete();
  endtask : chk_op
  initial begin
    rst_n = 1'b0;
    {qe, write_enable_latch, srst, lock} = 4'h0;
    ready = 1'b1;
    prot = '0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("reset", 7'h01, {busy, latch, cont, op_valid, wrap});
    rd(1, 24'h000120, 8'h20, 1, NW);
    chk("cont", 0, cont);
    qe = 1'b1;
    rd(1, 24'h000120, 8'h20, 4, NW);
    chk("cont", 1, cont);
    rd(0, 24'h000140, 8'hF5, 2, NW);
    chk("cont", 0, cont);
    rd(1, 24'h000120, 8'h20, 1, NW);
    chk("cont", 1, cont);
    // all ones on line zero as address and mode leaves continuous mode
    host.sel();
    host.sbyte(8'hFF);
    host.desel();
    chk("cont", 0, cont);
    for (int k = 0; k < 4; k++) begin
      wrap_set({1'b1, k[1:0], 5'h0F});
      chk("wrap", {k[1:0], 1'b0}, wrap);
      rd(1, 24'h000130, 8'h00, (8 << k) + 2, 8 << k);
    end
    wrap_set(8'h10);
    chk("wrap", 3'h1, wrap);
    rd(1, 24'h0001F0, 8'h00, 18, NW);
    wrap_set(8'h40);
    chk("wrap", 3'h4, wrap);
    pulse(srst);
    chk("wrap", 3'h1, wrap);
    wr(`SFRPE_CMD_PP, 24'h0004FE, 1, 0);
    chk_pgm(0, 0);
    chk_op(0, 0);
    pulse(write_enable_latch);
    n_busy = 0;
    wr(`SFRPE_CMD_PP, 24'h0004FE, 3, 0);
    chk_pgm(24'h0004FE, 3);
    chk_op(1, {1'b0, 24'h0004FE});
    chk("busy", 1, n_busy >= TPP && n_busy < TPP + 20);
    chk("latch", 0, latch);
    pulse(write_enable_latch);
    wr(`SFRPE_CMD_PP, 24'h000500, 1, 3);
    chk_op(0, 0);
    pq.delete();
    pulse(write_enable_latch);
    ready = 1'b0;
    wr(`SFRPE_CMD_QPP, 24'h000200, 2, 0);
    chk_op(0, 0);
    ready = 1'b1;
    settle();
    chk_pgm(24'h000200, 2);
    chk_op(1, {1'b0, 24'h000200});
    pulse(write_enable_latch);
    ready = 1'b0;
    n_abort = 0;
    wr(`SFRPE_CMD_PP, 24'h000300, 3, 0);
    ready = 1'b1;
    settle();
    chk("abort", 1, n_abort > 0);
    chk_op(0, 0);
    pq.delete();
    pulse(write_enable_latch);
    n_busy = 0;
    wr(`SFRPE_CMD_SE, 24'h012345, 0, 0);
    chk_op(1, {1'b1, 24'h012000});
    chk("busy", 1, n_busy >= TSE);
    chk("latch", 0, latch);
    pulse(write_enable_latch);
    wr(`SFRPE_CMD_SE, 24'h012345, 0, 1);
    chk_op(0, 0);
    prot = sfrpe_prot_t'(6'h07);
    wr(`SFRPE_CMD_SE, 24'h012345, 0, 0);
    chk_op(0, 0);
    chk("latch", 1, latch);
    prot = '0;
    lock = 1'b1;
    wr(`SFRPE_CMD_PP, 24'h000600, 1, 0);
    chk_op(0, 0);
    lock = 1'b0;
    end_sim();
  end
  // watchdog well beyond the expected run
  initial begin
    #1ms;
    err_count++;
    end_sim();
  end
endmodule : test_serial_flash_read_program_erase
